// *** hw/akp_audio_ctrl.sv ***
// Audio keyclick, bypass volume, mono select and power control registers
//
// Behaviour
// - Mute soft-steps gain down, then mutes; reverse.
// - Right bypass mute resets to one.
// - Seven-bit gain code, half-dB steps.
// - Gain code below 20h also mutes.
// - Gain field resets to unity code.
// - Writing click start launches one tone.
// - Three-bit click amplitude, reset medium.
// - Click frequency doubles per code step.
// - Click lasts (code+1)*2 tone periods.
// - Reserved keyclick bits read zero.
// - Mono select picks ADC or line mix.
// - Step rate 20 or 40 us.
// - Step done flag reads completion, resets one.
// - Upper power bits: one down, zero up.
// - Global power-down overrides, keeps bits.
// - Reference policy: on demand or sticky.
// - Mono driver pulls up inputs, left chain.
// - ADCs pull up inputs and own chain.
// - Bypass, headphone, DAC have own bits.
// - Power done flag low while sequencing.
`timescale 1ns/100ps
`include "akp_defines.svh"
module akp_audio_ctrl #(
  parameter int unsigned TONE_HALF_CYC = `AKP_TONE_HALF_CYC,
  parameter int unsigned VCM_START_CYC = `AKP_VCM_START_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Serial host port
  input wire logic host_sclk_i,
  input wire logic host_cs_n_i,
  input wire logic host_mosi_i,
  output logic host_miso_o,
  output logic host_miso_oe_n_o,
  // Analog controls
  output akp_pkg::akp_bypass_s right_bypass_o,
  output logic mono_source_select_o,
  output logic click_tone_o,
  output logic [2:0] click_amplitude_o,
  output akp_pkg::akp_power_s power_o
);
  import akp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Serial host port
  logic [2:0] sclk_q;
  logic [1:0] cs_n_q;
  logic [1:0] mosi_q;
  logic [5:0] bit_cnt_q;
  logic [15:0] shift_in_q;
  logic [15:0] shift_out_q;
  logic [15:0] cmd_q;
  logic miso_q;
  logic miso_oe_n_q;
  logic sclk_rise;
  logic wr_stb;
  logic [5:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  // Two flops per pin; the third sclk stage only feeds edge detection
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sclk_q <= 3'h0;
      cs_n_q <= 2'h3;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], host_sclk_i};
      cs_n_q <= {cs_n_q[0], host_cs_n_i};
      mosi_q <= {mosi_q[0], host_mosi_i};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2] & ~cs_n_q[1];
  assign wr_data = {shift_in_q[14:0], mosi_q[1]};
  assign wr_addr = cmd_q[`AKP_CMD_ADDR_HI:`AKP_CMD_ADDR_LO];
  // Write commits on the 32nd rising edge, page 2 only
  assign wr_stb = sclk_rise && bit_cnt_q == 6'h1F && !cmd_q[`AKP_CMD_READ_BIT]
    && cmd_q[`AKP_CMD_PAGE_HI:`AKP_CMD_PAGE_LO] == `AKP_PAGE;

  // Read data leaves on rising edges so it is stable at the next one
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || cs_n_q[1]) begin
      bit_cnt_q <= 6'h00;
      shift_in_q <= 16'h0000;
      shift_out_q <= 16'h0000;
      cmd_q <= 16'h0000;
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end else if (sclk_rise) begin
      shift_in_q <= wr_data;
      if (bit_cnt_q != 6'h20) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
      if (bit_cnt_q == 6'h0F) begin
        cmd_q <= wr_data;
        miso_q <= rd_data[15];
        shift_out_q <= {rd_data[14:0], 1'b0};
        miso_oe_n_q <= ~wr_data[`AKP_CMD_READ_BIT];
      end else if (bit_cnt_q > 6'h0F) begin
        miso_q <= shift_out_q[15];
        shift_out_q <= {shift_out_q[14:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [15:0] bypass_q;
  logic [15:0] keyclick_q;
  logic [7:0] power_q;
  logic step_done_q;
  logic power_done_q;
  logic click_end;

  // Read mux; reserved keyclick bits and unlisted addresses read zero
  function automatic logic [15:0] rd_data_f(input logic [15:0] cmd);
    logic [15:0] r;
    r = 16'h0000;
    if (cmd[`AKP_CMD_PAGE_HI:`AKP_CMD_PAGE_LO] == `AKP_PAGE) begin
      unique case (cmd[`AKP_CMD_ADDR_HI:`AKP_CMD_ADDR_LO])
        `AKP_BYPASS_VOL_OFS: r = bypass_q;
        `AKP_KEYCLICK_OFS: r = (keyclick_q & `AKP_KC_WMASK)
          | {15'h0000, step_done_q};
        `AKP_POWER_OFS: r = {power_q, power_done_q, 7'h00};
        default: r = 16'h0000;
      endcase
    end
    return r;
  endfunction
  assign rd_data = rd_data_f(wr_data); // Looked up as the command completes
  // Bypass volume register; resets muted at unity gain
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bypass_q <= `AKP_BYPASS_RESET;
    end else if (wr_stb && wr_addr == `AKP_BYPASS_VOL_OFS) begin
      bypass_q <= wr_data;
    end
  end
  // Keyclick register; a write of start wins over the self-clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      keyclick_q <= `AKP_KEYCLICK_RESET;
    end else if (wr_stb && wr_addr == `AKP_KEYCLICK_OFS) begin
      keyclick_q <= wr_data & `AKP_KC_WMASK;
    end else if (click_end) begin
      keyclick_q[`AKP_KC_START_BIT] <= 1'b0;
    end
  end
  // Upper power bits; low half belongs to other logic
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      power_q <= `AKP_PWR_UPPER_RESET;
    end else if (wr_stb && wr_addr == `AKP_POWER_OFS) begin
      power_q <= wr_data[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft-step engine for the right bypass gain
  logic [11:0] step_cnt_q;
  logic step_tick;
  akp_bypass_s bp_q;
  logic want_mute;
  logic [6:0] gain_set;

  // Step tick every 20 us, or 40 us at half rate
  assign step_tick = step_cnt_q == 12'h000;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || step_tick) begin
      step_cnt_q <= keyclick_q[`AKP_KC_RATE_BIT]
        ? 12'(2 * `AKP_STEP_CYC - 1) : 12'(`AKP_STEP_CYC - 1);
    end else begin
      step_cnt_q <= step_cnt_q - 12'h001;
    end
  end

  assign gain_set = bypass_q[6:0];
  assign want_mute = bypass_q[`AKP_BP_MUTE_BIT]
    || gain_set < `AKP_BP_GAIN_MIN;

  // Gain walks one code per tick; mute engages only at the floor
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bp_q <= '{muted: 1'b1, gain: `AKP_BP_GAIN_MIN};
    end else if (step_tick) begin
      if (want_mute) begin
        if (bp_q.gain > `AKP_BP_GAIN_MIN) begin
          bp_q.gain <= bp_q.gain - 7'h01;
        end else begin
          bp_q.muted <= 1'b1;
        end
      end else if (bp_q.muted) begin
        bp_q.muted <= 1'b0;
      end else if (bp_q.gain < gain_set) begin
        bp_q.gain <= bp_q.gain + 7'h01;
      end else if (bp_q.gain > gain_set) begin
        bp_q.gain <= bp_q.gain - 7'h01;
      end
    end
  end
  // Done one cycle after target and applied state agree
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      step_done_q <= 1'b1;
    end else begin
      step_done_q <= want_mute
        ? (bp_q.muted && bp_q.gain == `AKP_BP_GAIN_MIN)
        : (!bp_q.muted && bp_q.gain == gain_set);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Keyclick tone generator
  logic [18:0] half_cnt_q;
  logic [5:0] halves_q;
  logic tone_q;
  logic click_run_q;

  // Half period halves per code step: 62.5 Hz at 000 to 8 kHz at 111
  function automatic logic [18:0] half_len_f(input logic [2:0] code);
    return 19'((TONE_HALF_CYC >> code) - 1);
  endfunction

  assign click_end = click_run_q && half_cnt_q == 19'h00000
    && halves_q == 6'h00;

  // Clearing start mid-tone aborts it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !keyclick_q[`AKP_KC_START_BIT] || click_end) begin
      click_run_q <= 1'b0;
      tone_q <= 1'b0;
      half_cnt_q <= 19'h00000;
      halves_q <= 6'h00;
    end else if (!click_run_q) begin
      click_run_q <= 1'b1;
      tone_q <= 1'b1;
      half_cnt_q <= half_len_f(keyclick_q[10:8]);
      halves_q <= {keyclick_q[7:4], 2'b11};
    end else if (half_cnt_q == 19'h00000) begin
      tone_q <= ~tone_q;
      half_cnt_q <= half_len_f(keyclick_q[10:8]);
      halves_q <= halves_q - 6'h01;
    end else begin
      half_cnt_q <= half_cnt_q - 19'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control
  akp_power_s pwr_d;
  akp_power_s pwr_q;
  logic [14:0] settle_q;
  logic any_up;

  // Global bit masks all sections except a reference held on by the sticky policy; individual bits are kept
  always_comb begin
    pwr_d = '0;
    if (!power_q[7]) begin
      pwr_d.bypass = !power_q[5];
      pwr_d.headphone_amp = !power_q[4];
      pwr_d.mono_driver = !power_q[3];
      pwr_d.stereo_dac = !power_q[2];
      pwr_d.left_adc = !power_q[1];
      pwr_d.right_adc = !power_q[0];
    end
    pwr_d.line_inputs = pwr_d.mono_driver || pwr_d.left_adc
      || pwr_d.right_adc;
    pwr_d.mic_preamp = pwr_d.line_inputs;
    pwr_d.left_mux_vol = pwr_d.mono_driver || pwr_d.left_adc;
    pwr_d.right_mux_vol = pwr_d.right_adc;
    any_up = pwr_d.bypass || pwr_d.stereo_dac || pwr_d.line_inputs
      || pwr_d.headphone_amp;
    // Sticky policy saves the slow reference start-up on re-use
    pwr_d.midrail_reference = any_up
      || (!power_q[6] && pwr_q.midrail_reference);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pwr_q <= '0;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Reference start-up dominates; other sections settle quickly
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      settle_q <= 15'h0000;
    end else if (pwr_d.midrail_reference && !pwr_q.midrail_reference) begin
      settle_q <= 15'(VCM_START_CYC);
    end else if (pwr_d != pwr_q && settle_q < 15'(`AKP_SETTLE_CYC)) begin
      settle_q <= 15'(`AKP_SETTLE_CYC);
    end else if (settle_q != 15'h0000) begin
      settle_q <= settle_q - 15'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      power_done_q <= 1'b1;
    end else begin
      power_done_q <= settle_q == 15'h0000 && pwr_d == pwr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  logic mono_q;
  logic [2:0] amp_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mono_q <= 1'b0;
      amp_q <= 3'h4;
    end else begin
      mono_q <= keyclick_q[`AKP_KC_MONO_BIT];
      amp_q <= keyclick_q[14:12];
    end
  end

  assign host_miso_o = miso_q;
  assign host_miso_oe_n_o = miso_oe_n_q;
  assign right_bypass_o = bp_q;
  assign mono_source_select_o = mono_q;
  assign click_tone_o = tone_q;
  assign click_amplitude_o = amp_q;
  assign power_o = pwr_q;

endmodule // akp_audio_ctrl

// *** hw/akp_defines.svh ***
// Offsets, field positions, reset values and timing counts of the block
`ifndef AKP_DEFINES_SVH
`define AKP_DEFINES_SVH

// Serial command word layout
`define AKP_CMD_READ_BIT 15
`define AKP_CMD_PAGE_HI 14
`define AKP_CMD_PAGE_LO 11
`define AKP_CMD_ADDR_HI 10
`define AKP_CMD_ADDR_LO 5
`define AKP_PAGE 4'h2

// Register offsets within the page
`define AKP_BYPASS_VOL_OFS 6'h03
`define AKP_KEYCLICK_OFS 6'h04
`define AKP_POWER_OFS 6'h05

// Bypass volume field
`define AKP_BP_MUTE_BIT 7
`define AKP_BP_GAIN_MIN 7'h20
`define AKP_BYPASS_RESET 16'h80E7

// Keyclick register fields
`define AKP_KC_START_BIT 15
`define AKP_KC_MONO_BIT 2
`define AKP_KC_RATE_BIT 1
`define AKP_KC_DONE_BIT 0
`define AKP_KC_WMASK 16'hF7F6
`define AKP_KEYCLICK_RESET 16'h4410

// Power register fields
`define AKP_PWR_UPPER_RESET 8'hFF
`define AKP_PWR_DONE_BIT 7

// Timing, in ns, and derived cycle counts
`define AKP_CLK_NS 20
`define AKP_STEP_NS 20000
`define AKP_STEP_CYC (`AKP_STEP_NS / `AKP_CLK_NS)
`define AKP_SETTLE_NS 1000
`define AKP_SETTLE_CYC (`AKP_SETTLE_NS / `AKP_CLK_NS)
`define AKP_VCM_START_NS 500000
`define AKP_VCM_START_CYC (`AKP_VCM_START_NS / `AKP_CLK_NS)
`define AKP_TONE_HALF_NS 8000000
`define AKP_TONE_HALF_CYC (`AKP_TONE_HALF_NS / `AKP_CLK_NS)

`endif

// *** hw/akp_pkg.sv ***
// Types shared by the audio keyclick and power control block
package akp_pkg;

  // Effective power state of every audio section, 1 = powered
  typedef struct packed {
    logic midrail_reference;
    logic bypass;
    logic headphone_amp;
    logic mono_driver;
    logic stereo_dac;
    logic left_adc;
    logic right_adc;
    logic line_inputs;
    logic mic_preamp;
    logic left_mux_vol;
    logic right_mux_vol;
  } akp_power_s;

  // Right bypass gain as applied to the analog path
  typedef struct packed {
    logic muted;
    logic [6:0] gain;
  } akp_bypass_s;

endpackage

// *** dv/akp_audio_ctrl_monitor.sv ***
// Assertion checker for the audio keyclick and power control block
`timescale 1ns/100ps
`include "akp_defines.svh"
module akp_audio_ctrl_monitor (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Analog controls
  input wire akp_pkg::akp_bypass_s right_bypass_o,
  input wire akp_pkg::akp_power_s power_o
);
  import akp_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since the last gain step; saturates so reset never fakes a step
  logic [6:0] gain_prev_q;
  logic [11:0] since_q;
  always_ff @(posedge ref_clk_i) begin
    gain_prev_q <= right_bypass_o.gain;
    if (!rst_n_i) begin
      since_q <= 12'hFFF;
    end else if (right_bypass_o.gain != gain_prev_q) begin
      since_q <= 12'h001;
    end else if (since_q != 12'hFFF) begin
      since_q <= since_q + 12'h001;
    end
  end
  // Steps ride the tick, so no two may come closer than one tick
  property p_step_gap;
    $changed(right_bypass_o.gain) |-> since_q >= 12'(`AKP_STEP_CYC);
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("bypass steps closer than one tick");
  ////////////////////////////////////////////////////////////////////////////
  // A step must move one code and be followed by a quiet stretch of eight cycles
  sequence s_hold;
    $stable(right_bypass_o.gain) [*8];
  endsequence
  property p_floor;
    right_bypass_o.gain >= 7'h20;
  endproperty
  a_floor: assert property (p_floor)
    else $error("bypass gain below floor");
  property p_step;
    $changed(right_bypass_o.gain) |-> (right_bypass_o.gain ==
      $past(right_bypass_o.gain) + 7'h01) || (right_bypass_o.gain ==
      $past(right_bypass_o.gain) - 7'h01);
  endproperty
  a_step: assert property (p_step)
    else $error("bypass gain jumped");
  property p_spacing;
    $changed(right_bypass_o.gain) |=> s_hold;
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("bypass steps too close");
  property p_mute;
    $rose(right_bypass_o.muted) |-> right_bypass_o.gain == 7'h20;
  endproperty
  a_mute: assert property (p_mute)
    else $error("muted before reaching floor");
  property p_unmute;
    $fell(right_bypass_o.muted) |-> right_bypass_o.gain == 7'h20;
  endproperty
  a_unmute: assert property (p_unmute)
    else $error("unmuted away from floor");
  property p_ref;
    (|power_o[9:0]) |-> power_o.midrail_reference;
  endproperty
  a_ref: assert property (p_ref)
    else $error("section on without reference");
  property p_left;
    (power_o.left_adc || power_o.mono_driver) |-> power_o.line_inputs &&
      power_o.mic_preamp && power_o.left_mux_vol;
  endproperty
  a_left: assert property (p_left)
    else $error("left chain not powered");
  property p_right;
    power_o.right_adc |-> power_o.line_inputs && power_o.mic_preamp &&
      power_o.right_mux_vol;
  endproperty
  a_right: assert property (p_right)
    else $error("right chain not powered");
endmodule // akp_audio_ctrl_monitor

bind akp_audio_ctrl akp_audio_ctrl_monitor i_akp_audio_ctrl_monitor (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .right_bypass_o(right_bypass_o),
  .power_o(power_o)
);

// *** dv/tb_top.sv ***
// Self-checking testbench for the audio keyclick and power control block
`timescale 1ns/100ps
`include "akp_defines.svh"
module tb_top;
  import akp_pkg::*;
  localparam int unsigned HALF = 256;
  logic clk = 0, rst_n = 0, sclk = 0, cs_n = 1, mosi = 0, miso, oe_n;
  logic mono, tone, tone_q = 0;
  logic [2:0] amp, a3;
  logic [3:0] len;
  logic [15:0] r, exp_q[$], got_q[$];
  akp_bypass_s byp;
  akp_power_s pwr;
  int failures = 0, cmp_count = 0, cyc = 0, tog = 0, gap = 0, last_gap = 0;
  integer seed = 32'h8828;
  logic [6:0] gain_seen = 7'h20;
  logic oe_seen = 1'b1;
  int bgap = 0, last_bgap = 0;
  // Power upper byte and the sections expected on
  logic [18:0] ptab [7] = '{
    {8'h7D, 11'h42E},
    {8'hFD, 11'h000},
    {8'h7E, 11'h41D},
    {8'h77, 11'h48E},
    {8'h4B, 11'h740},
    {8'h3F, 11'h400},
    {8'h7F, 11'h000}};
  akp_audio_ctrl #(.TONE_HALF_CYC(HALF), .VCM_START_CYC(1000))
    i_akp_audio_ctrl (
    .ref_clk_i(clk), .rst_n_i(rst_n), .host_sclk_i(sclk),
    .host_cs_n_i(cs_n), .host_mosi_i(mosi), .host_miso_o(miso),
    .host_miso_oe_n_o(oe_n), .right_bypass_o(byp),
    .mono_source_select_o(mono), .click_tone_o(tone),
    .click_amplitude_o(amp), .power_o(pwr));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Note an expectation beside the value seen
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    got_q.push_back(g);
    exp_q.push_back(e);
  endtask
  // Oldest note against oldest result; stops a hung run too
  always @(posedge clk) begin
    while (got_q.size() > 0) begin
      cmp_count++;
      r = got_q.pop_front();
      if (r !== exp_q[0]) begin
        failures++;
        $display("[FAIL] %0t got %h exp %h", $time, r, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    cyc++;
    if (cyc == 80000) begin
      failures++;
      end_of_test();
    end
  end
  // Tone edges and gain steps, with the cycles between the last two
  always @(negedge clk) begin
    gap++;
    bgap++;
    if (tone !== tone_q) begin
      tog++;
      last_gap = gap;
      gap = 0;
    end
    if (byp.gain !== gain_seen) begin
      last_bgap = bgap;
      bgap = 0;
    end
    tone_q = tone;
    gain_seen = byp.gain;
  end
  // One 32-bit frame; sclk phases of 5 cycles keep above the minimum
  task automatic frame(input logic [31:0] w, output logic [15:0] q);
    cs_n = 0;
    repeat (5) @(negedge clk);
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      repeat (5) @(negedge clk);
      if (i < 16) q[i] = miso;
      if (i == 8) oe_seen = oe_n;
      sclk = 1;
      repeat (5) @(negedge clk);
      sclk = 0;
    end
    cs_n = 1;
    repeat (6) @(negedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] q;
    frame({1'b0, `AKP_PAGE, a, 5'h00, d}, q);
    chk({15'h0000, oe_seen}, 16'h0001); // Data pin stays released
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] q;
    frame({1'b1, `AKP_PAGE, a, 5'h00, 16'h0000}, q);
    chk(q, e);
    chk({15'h0000, oe_seen}, 16'h0000); // Data pin driven in the data phase
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    chk({8'h00, byp}, 16'h00A0);
    chk({13'h0000, amp}, 16'h0004);
    chk({5'h00, pwr}, 16'h0000);
    chk({15'h0000, mono}, 16'h0000);
    rd(6'h03, 16'h80E7);
    rd(6'h04, 16'h4411);
    rd(6'h05, 16'hFF80);
    rd(6'h06, 16'h0000);
    wr(6'h04, 16'h0F0E);
    rd(6'h04, 16'h0707);
    chk({15'h0000, mono}, 16'h0001);
    // Each fast tone code with random length and level
    for (int f = 4; f < 8; f++) begin
      len = 4'($random(seed) & 3);
      a3 = 3'($random(seed));
      tog = 0;
      wr(6'h04, {1'b1, a3, 1'b0, f[2:0], len, 4'h0});
      repeat ((len + 1) * 4 * (HALF >> f) + 20) @(negedge clk);
      chk(16'(tog), 16'((len + 1) * 4));
      chk(16'(last_gap), 16'(HALF >> f));
      chk({13'h0000, amp}, {13'h0000, a3});
      rd(6'h04, {1'b0, a3, 1'b0, f[2:0], len, 4'h1});
    end
    // Unmute to a low gain, then mute with a code under the floor
    wr(6'h04, 16'h0000);
    wr(6'h03, 16'h0025);
    rd(6'h04, 16'h0000);
    repeat (7000) @(negedge clk);
    chk({8'h00, byp}, 16'h0025);
    chk(16'(last_bgap), 16'(`AKP_STEP_CYC));
    rd(6'h04, 16'h0001);
    wr(6'h03, 16'h0012);
    repeat (7000) @(negedge clk);
    chk({8'h00, byp}, 16'h00A0);
    rd(6'h03, 16'h0012);
    // Half step rate doubles the spacing of gain steps
    wr(6'h04, 16'h0002);
    wr(6'h03, 16'h0022);
    repeat (7000) @(negedge clk);
    chk({8'h00, byp}, 16'h0022);
    chk(16'(last_bgap), 16'(2 * `AKP_STEP_CYC));
    // Power settings with fan-out, override and reference policy
    foreach (ptab[k]) begin
      wr(6'h05, {ptab[k][18:11], 8'h00});
      if (k == 0) rd(6'h05, {ptab[k][18:11], 8'h00});
      repeat (1200) @(negedge clk);
      chk({5'h00, pwr}, {5'h00, ptab[k][10:0]});
      rd(6'h05, {ptab[k][18:11], 8'h80});
    end
    repeat (3) @(negedge clk);
    end_of_test();
  end
endmodule // tb_top
